// ### logic/prog_port_pkg.sv
// constants and types shared by the programming port and its programmer
// assumes: one 25 MHz clock, synchronous active-low reset on both ends
package prog_port_pkg;
	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 12;
	localparam int          OPT_BITS     = 3;
	localparam int          OPT_LOCS     = 8;
	localparam logic [7:0]  MODE_OPTION  = 8'h03;
	localparam logic [11:0] OPT_SEL_ADDR = 12'h003;
	localparam logic [11:0] ADDR_RESET   = 12'h000;
	localparam logic [7:0]  MODE_RESET   = 8'h00;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;
	localparam int          DIV_HALF     = 2;
	typedef enum logic [3:0] {
		P_IDLE   = 4'b0000,
		P_CLR    = 4'b0001,
		P_CLKHI  = 4'b0010,
		P_CLKLO  = 4'b0011,
		P_LATCH  = 4'b0100,
		P_LATLO  = 4'b0101,
		P_CLR2   = 4'b0110,
		P_WRITE  = 4'b0111,
		P_WREND  = 4'b1000,
		P_RDSET  = 4'b1001,
		P_RDCAP  = 4'b1010,
		P_DONE   = 4'b1011
	} prog_state_t;
endpackage

// ### logic/prog_port_if.sv
// pins between the programmer and the device programming port
// assumes: the bench resolves the shared data wire from the enables
`timescale 1ns/1ps
interface prog_port_if;
	import prog_port_pkg::*;
	logic              highVolt;
	logic              modeLatch;
	logic              dirPrecharge;
	logic              option_read_enable;
	logic              clampBypass;
	logic              chipSelN;
	logic              program_strobe_n;
	logic              addrCountClk;
	logic              addr_count_clear;
	logic [DATA_W-1:0] hostDataOut;
	logic              hostDataOe;
	logic [DATA_W-1:0] devDataOut;
	logic              devDataOe;
	logic [DATA_W-1:0] dataIn;
	modport device (input highVolt, modeLatch, dirPrecharge,
		option_read_enable, clampBypass, chipSelN, program_strobe_n,
		addrCountClk, addr_count_clear, dataIn,
		output devDataOut, devDataOe);
	modport host (output highVolt, modeLatch, dirPrecharge,
		option_read_enable, clampBypass, chipSelN, program_strobe_n,
		addrCountClk, addr_count_clear, hostDataOut, hostDataOe,
		input dataIn);
endinterface

// ### logic/eprom_program_port.sv
// device end: programming port with array, counter and mode register
// assumes: all pins come from outside and are filtered by three flops
`timescale 1ns/1ps
module eprom_program_port
	import prog_port_pkg::*;
#(
	parameter int DEPTH = 4096
) (
	input  wire logic              clk,           // system clock
	input  wire logic              rstn,          // sync reset, low
	prog_port_if.device            pins,          // programming pins
	input  wire logic              protect,       // array read protection
	output logic                   progActive,    // detect, port owns pins
	output logic [DATA_W-1:0]      modeReg,       // latched mode
	output logic [OPT_BITS-1:0]    optionBits,    // option bits in use
	output logic                   clampEnable,   // voltage clamp on
	output logic                   prechargeOn,   // array precharge
	output logic [ADDR_W-1:0]      address        // counter value
);
	initial begin
		if (DEPTH < OPT_LOCS || DEPTH > (1 << ADDR_W))
			$error("DEPTH out of range");
	end

	// ======================================================
	// pin filter
	localparam int NP = 9;
	logic [NP-1:0] s1_r, s2_r, s3_r, pin_r;
	logic [DATA_W-1:0] d1_r, d2_r, d3_r;
	wire  [NP-1:0] rawPins = {pins.highVolt, pins.modeLatch,
		pins.dirPrecharge, pins.option_read_enable, pins.clampBypass,
		pins.chipSelN, pins.program_strobe_n, pins.addrCountClk,
		pins.addr_count_clear};
	wire  [NP-1:0] agree = ~(s2_r ^ s3_r);

	// synchroniser runs through reset so pin levels are settled at release
	always_ff @(posedge clk) begin
		s1_r <= rawPins;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// filtered pins reset to their idle levels: dir, select, strobe high
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_r <= 9'h04c;
			d1_r  <= '0;
			d2_r  <= '0;
			d3_r  <= '0;
		end else begin
			pin_r <= (agree & s3_r) | (~agree & pin_r);
			d1_r  <= pins.dataIn;
			d2_r  <= d1_r;
			d3_r  <= d2_r;
		end
	end

	wire detect   = pin_r[8];
	wire latchIn  = pin_r[7] & detect;
	wire dirIn    = pin_r[6];
	wire clampByp = pin_r[4] & detect;
	wire csActive = ~pin_r[3] & detect;
	wire strobeLo = ~pin_r[2];
	wire cntClk   = pin_r[1] & detect;
	wire cntClr   = pin_r[0] & detect;

	// ======================================================
	// edges, counter and mode register
	logic latchD_r, clkD_r, strobeD_r, optRead_r, optCaught_r;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] mode_r;
	wire clkRise   = cntClk & ~clkD_r;
	wire latchRise = latchIn & ~latchD_r;
	wire writeNow  = detect & csActive & strobeLo & ~strobeD_r
		& dirIn;

	assign addr_nxt = cntClr ? ADDR_RESET
		: clkRise ? addr_r + 12'h001 : addr_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			latchD_r    <= 1'b0;
			clkD_r      <= 1'b0;
			strobeD_r   <= 1'b0;
			addr_r      <= ADDR_RESET;
			mode_r      <= MODE_RESET;
			optCaught_r <= 1'b0;
			optRead_r   <= 1'b0;
		end else begin
			latchD_r  <= latchIn;
			clkD_r    <= cntClk;
			strobeD_r <= strobeLo & detect;
			addr_r    <= addr_nxt;
			if (latchRise)
				mode_r <= d3_r;
			// option read level caught once after reset release
			if (!optCaught_r) begin
				optCaught_r <= 1'b1;
				optRead_r   <= s2_r[5] & s3_r[5];
			end
		end
	end

	// ======================================================
	// array and option locations
	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [DATA_W-1:0] opt_r;
	logic [DATA_W-1:0] rd_r;
	wire optMode  = (mode_r == MODE_OPTION);
	wire [ADDR_W-1:0] idx = ADDR_W'(int'(addr_r) % DEPTH);
	wire readOk   = ~protect | optRead_r;
	wire [DATA_W-1:0] rdData = optMode ? opt_r
		: (readOk ? mem_r[idx] : ERASED_BYTE);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			opt_r <= ERASED_BYTE;
			rd_r  <= '0;
		end else begin
			// location zero in option mode writes all option bits
			if (writeNow && optMode && addr_r == ADDR_RESET)
				opt_r <= opt_r & d3_r;
			if (detect && csActive && !dirIn)
				rd_r <= rdData;
		end
	end

	// blank array at reset; a written cell can only clear bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= ERASED_BYTE;
		end else if (writeNow && !optMode) begin
			mem_r[idx] <= mem_r[idx] & d3_r;
		end
	end

	// ======================================================
	// outputs
	assign pins.devDataOut = rd_r;
	assign pins.devDataOe  = detect & csActive & ~dirIn;
	assign progActive      = detect;
	assign modeReg         = mode_r;
	assign optionBits      = opt_r[OPT_BITS-1:0];
	assign clampEnable     = ~clampByp;
	assign prechargeOn     = detect & dirIn;
	assign address         = addr_r;
endmodule

// ### logic/eprom_programmer.sv
// programmer end: walks the option-bit sequence, then reads back
// assumes: device samples pins through three flops, so each step holds
`timescale 1ns/1ps
module eprom_programmer
	import prog_port_pkg::*;
#(
	parameter int HOLD = 8
) (
	input  wire logic              clk,          // system clock
	input  wire logic              rstn,         // sync reset, low
	prog_port_if.host              pins,         // programming pins
	input  wire logic              startValid,   // request option write
	output logic                   startReady,   // idle, can take request
	input  wire logic [DATA_W-1:0] optData,      // option byte to write
	output logic                   rdValid,      // read-back word ready
	input  wire logic              rdReady,      // receiver takes word
	output logic [DATA_W-1:0]      rdData        // read-back option byte
);
	initial begin
		if (HOLD < 4 || HOLD > 255)
			$error("HOLD out of range");
	end

	// ======================================================
	// sequencer
	prog_state_t st_r, st_nxt;
	logic [7:0] hold_r;
	logic [1:0] clks_r;
	logic [DATA_W-1:0] opt_r;
	wire stepDone = (hold_r == 8'(HOLD - 1));
	wire bufReady;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			P_IDLE:  if (startValid)            st_nxt = P_CLR;
			P_CLR:   if (stepDone)              st_nxt = P_CLKHI;
			P_CLKHI: if (stepDone)              st_nxt = P_CLKLO;
			P_CLKLO: if (stepDone)
				st_nxt = (clks_r == 2'd2) ? P_LATCH : P_CLKHI;
			P_LATCH: if (stepDone)              st_nxt = P_LATLO;
			P_LATLO: if (stepDone)              st_nxt = P_CLR2;
			P_CLR2:  if (stepDone)              st_nxt = P_WRITE;
			P_WRITE: if (stepDone)              st_nxt = P_WREND;
			P_WREND: if (stepDone)              st_nxt = P_RDSET;
			P_RDSET: if (stepDone)              st_nxt = P_RDCAP;
			P_RDCAP: if (stepDone && bufReady)  st_nxt = P_DONE;
			P_DONE:                             st_nxt = P_IDLE;
			default:                            st_nxt = P_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r   <= P_IDLE;
			hold_r <= 8'h00;
			clks_r <= 2'd0;
			opt_r  <= 8'h00;
		end else begin
			st_r   <= st_nxt;
			hold_r <= (st_nxt != st_r) ? 8'h00
				: (stepDone ? hold_r : hold_r + 8'h01);
			if (st_r == P_IDLE && startValid)
				opt_r <= optData;
			if (st_r == P_CLR)
				clks_r <= 2'd0;
			else if (st_r == P_CLKLO && stepDone)
				clks_r <= clks_r + 2'd1;
		end
	end

	// ======================================================
	// pin drive
	wire active = (st_r != P_IDLE);
	wire reading = (st_r == P_RDSET) || (st_r == P_RDCAP);
	assign pins.highVolt           = active;
	assign pins.addr_count_clear   = (st_r == P_CLR)
		|| (st_r == P_CLR2);
	assign pins.addrCountClk       = (st_r == P_CLKHI);
	assign pins.modeLatch          = (st_r == P_LATCH);
	assign pins.dirPrecharge       = ~reading;
	assign pins.program_strobe_n   = ~(st_r == P_WRITE);
	assign pins.chipSelN           = ~active;
	assign pins.option_read_enable = 1'b0;
	assign pins.clampBypass        = 1'b0;
	assign pins.hostDataOe         = active & ~reading;
	assign pins.hostDataOut        = (st_r == P_WRITE || st_r == P_WREND)
		? opt_r : MODE_OPTION;
	assign startReady              = ~active;

	// ======================================================
	// two-entry read-back buffer
	logic [DATA_W-1:0] buf_r [2];
	logic wp_r, rp_r;
	logic [1:0] cnt_r;
	wire push = (st_r == P_RDCAP) && stepDone && bufReady;
	wire pop  = rdValid && rdReady;
	assign bufReady = (cnt_r != 2'd2);
	assign rdValid  = (cnt_r != 2'd0);
	assign rdData   = buf_r[rp_r];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wp_r     <= 1'b0;
			rp_r     <= 1'b0;
			cnt_r    <= 2'd0;
			buf_r[0] <= 8'h00;
			buf_r[1] <= 8'h00;
		end else begin
			if (push) begin
				buf_r[wp_r] <= pins.dataIn;
				wp_r        <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ### testbench/prog_port_props.sv
// checker on the pins between the programmer and the device end
// assumes: clk and rstn of both ends, signals taken from the interface
`timescale 1ns/1ps
module prog_port_props
	import prog_port_pkg::*;
(
	input wire logic              clk,              // clock
	input wire logic              rstn,             // sync reset, low
	input wire logic              highVolt,         // programming voltage
	input wire logic              modeLatch,        // mode capture
	input wire logic              dirPrecharge,     // direction
	input wire logic              chipSelN,         // chip select
	input wire logic              program_strobe_n, // write strobe
	input wire logic              addrCountClk,     // counter clock
	input wire logic              addr_count_clear, // counter clear
	input wire logic [DATA_W-1:0] hostDataOut,      // programmer data
	input wire logic              hostDataOe,       // programmer drives
	input wire logic              devDataOe         // device drives
);
	// ==========================================================
	// counter pulses seen since the last clear
	logic [3:0] pulseCnt_r;
	logic       clkPrev_r;
	always_ff @(posedge clk) begin
		if (!rstn || addr_count_clear)
			pulseCnt_r <= 4'h0;
		else if (addrCountClk && !clkPrev_r)
			pulseCnt_r <= pulseCnt_r + 4'h1;
		clkPrev_r <= rstn && addrCountClk;
	end
	// ==========================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence outEnabled;
		highVolt && !dirPrecharge && !chipSelN;
	endsequence
	sequence strobeHeld;
		!program_strobe_n [*4];
	endsequence
	drive_read_only_a: assert property ($rose(devDataOe) |-> outEnabled)
		else $error("device drives data outside a read");
	quiet_no_volt_a: assert property (!highVolt [*8] |-> !devDataOe)
		else $error("device drives data without voltage");
	latch_mode_three_a: assert property ($rose(modeLatch) |->
		hostDataOe && hostDataOut == MODE_OPTION)
		else $error("mode latched with wrong data");
	latch_after_three_a: assert property ($rose(modeLatch) |->
		pulseCnt_r == 4'h3 && highVolt)
		else $error("mode latched at wrong count");
	write_loc_zero_a: assert property ($fell(program_strobe_n) |->
		pulseCnt_r == 4'h0 && highVolt && dirPrecharge && hostDataOe)
		else $error("write strobe at wrong place");
	strobe_held_a: assert property ($fell(program_strobe_n) |-> strobeHeld)
		else $error("write strobe too short");
	clock_under_volt_a: assert property ($rose(addrCountClk) |->
		highVolt ##1 addrCountClk [*3])
		else $error("counter clock short or without voltage");
	release_on_dir_a: assert property ($rose(dirPrecharge) |->
		##[1:8] !devDataOe)
		else $error("device keeps driving after turn");
endmodule

// ### testbench/eprom_program_port_tb_top.sv
// bench: programmer and device joined, plus a device driven by hand
// assumes: package, interface and both ends compiled first
`timescale 1ns/1ps
module eprom_program_port_tb_top;
	import prog_port_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        protect = 1'b0;
	logic        startValid = 1'b0;
	logic        rdReady = 1'b0;
	logic [7:0]  optData = 8'h00;
	logic [7:0]  busLast = 8'h00;
	logic [7:0]  bus2Last = 8'h00;
	logic        startReady, rdValid, progActive, clampEnable, prechargeOn;
	logic        progActive2, clampEnable2, prechargeOn2;
	logic [7:0]  rdData, modeReg, modeReg2;
	logic [2:0]  optionBits, optionBits2;
	logic [11:0] address, address2;
	int          n_errors = 0;
	int          samples_checked = 0;
	prog_port_if link ();
	prog_port_if loose ();
	// ==========================================================
	// shared data wires: released lines show the inverse of the last value
	assign link.dataIn = link.hostDataOe ? link.hostDataOut :
		link.devDataOe ? link.devDataOut : ~busLast;
	assign loose.dataIn = loose.hostDataOe ? loose.hostDataOut :
		loose.devDataOe ? loose.devDataOut : ~bus2Last;
	always @(posedge clk) begin
		busLast <= link.dataIn;
		bus2Last <= loose.dataIn;
	end
	initial begin
		forever #20 clk = ~clk;
	end
	eprom_program_port #(.DEPTH(4096)) eprom_program_port_inst (.clk(clk),
		.rstn(rstn), .pins(link), .protect(protect), .progActive(progActive),
		.modeReg(modeReg), .optionBits(optionBits), .clampEnable(clampEnable),
		.prechargeOn(prechargeOn), .address(address));
	eprom_program_port #(.DEPTH(4096)) eprom_program_port_inst2 (.clk(clk),
		.rstn(rstn), .pins(loose), .protect(protect),
		.progActive(progActive2), .modeReg(modeReg2),
		.optionBits(optionBits2), .clampEnable(clampEnable2),
		.prechargeOn(prechargeOn2), .address(address2));
	eprom_programmer #(.HOLD(8)) eprom_programmer_inst (.clk(clk),
		.rstn(rstn), .pins(link), .startValid(startValid),
		.startReady(startReady), .optData(optData), .rdValid(rdValid),
		.rdReady(rdReady), .rdData(rdData));
	prog_port_props prog_port_props_inst (.clk(clk), .rstn(rstn),
		.highVolt(link.highVolt), .modeLatch(link.modeLatch),
		.dirPrecharge(link.dirPrecharge), .chipSelN(link.chipSelN),
		.program_strobe_n(link.program_strobe_n),
		.addrCountClk(link.addrCountClk),
		.addr_count_clear(link.addr_count_clear),
		.hostDataOut(link.hostDataOut), .hostDataOe(link.hostDataOe),
		.devDataOe(link.devDataOe));
	// ==========================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_hi(input logic forStart);
		for (int i = 0; i < 600; i++) begin
			if ((forStart ? startReady : rdValid) === 1'b1)
				return;
			step(1);
		end
		n_errors++;
		$display("BAD t=%0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			loose.addrCountClk = 1'b1;
			step(8);
			loose.addrCountClk = 1'b0;
			step(8);
		end
	endtask
	task automatic latch_mode(input logic [7:0] m);
		loose.hostDataOut = m;
		loose.modeLatch = 1'b1;
		step(8);
		loose.modeLatch = 1'b0;
		step(8);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_after_reset;
		check(12'(progActive), 12'h000);
		check(address, 12'h000);
		check(12'(modeReg), 12'h000);
		check(12'(optionBits), 12'h007);
		check(12'(link.devDataOe), 12'h000);
	endtask
	task automatic t_option(input logic [7:0] opt, input logic [2:0] expOpt);
		wait_hi(1'b1);
		startValid = 1'b1;
		optData = opt;
		step(1);
		startValid = 1'b0;
		wait_hi(1'b0);
		check(12'(modeReg), 12'(MODE_OPTION));
		check(12'(optionBits), 12'(expOpt));
		check(12'(clampEnable), 12'h001);
		step(5);
		check(12'(rdValid), 12'h001);
		check(12'(rdData[2:0]), 12'(expOpt));
		rdReady = 1'b1;
		step(1);
		rdReady = 1'b0;
		check(12'(rdValid), 12'h000);
	endtask
	task automatic t_no_volt;
		pulses(3);
		latch_mode(MODE_OPTION);
		loose.program_strobe_n = 1'b0;
		step(8);
		loose.program_strobe_n = 1'b1;
		loose.chipSelN = 1'b0;
		loose.dirPrecharge = 1'b0;
		loose.hostDataOe = 1'b0;
		step(8);
		check(address2, 12'h000);
		check(12'(modeReg2), 12'h000);
		check(12'(progActive2), 12'h000);
		check(12'(loose.devDataOe), 12'h000);
	endtask
	task automatic t_pins;
		loose.chipSelN = 1'b1;
		loose.dirPrecharge = 1'b1;
		loose.hostDataOe = 1'b1;
		loose.highVolt = 1'b1;
		step(8);
		check(12'(progActive2), 12'h001);
		check(12'(prechargeOn2), 12'h001);
		pulses(3);
		check(address2, 12'h003);
		latch_mode(MODE_OPTION);
		check(12'(modeReg2), 12'(MODE_OPTION));
		loose.addr_count_clear = 1'b1;
		step(8);
		loose.addr_count_clear = 1'b0;
		check(address2, 12'h000);
		loose.clampBypass = 1'b1;
		loose.chipSelN = 1'b0;
		loose.dirPrecharge = 1'b0;
		loose.hostDataOe = 1'b0;
		step(8);
		check(12'(clampEnable2), 12'h000);
		check(12'(loose.devDataOe), 12'h001);
		check(12'(prechargeOn2), 12'h000);
		loose.chipSelN = 1'b1;
		step(8);
		check(12'(loose.devDataOe), 12'h000);
	endtask
	task automatic t_array(input logic [7:0] dat, input logic [7:0] expProt);
		loose.dirPrecharge = 1'b1;
		loose.hostDataOe = 1'b1;
		latch_mode(8'h01);
		check(12'(modeReg2), 12'h001);
		loose.addr_count_clear = 1'b1;
		loose.hostDataOut = dat;
		step(8);
		loose.addr_count_clear = 1'b0;
		loose.chipSelN = 1'b0;
		loose.program_strobe_n = 1'b0;
		step(8);
		loose.program_strobe_n = 1'b1;
		step(8);
		loose.dirPrecharge = 1'b0;
		loose.hostDataOe = 1'b0;
		step(8);
		check(12'(loose.devDataOut), 12'(dat));
		protect = 1'b1;
		step(8);
		check(12'(loose.devDataOut), 12'(expProt));
		protect = 1'b0;
		loose.chipSelN = 1'b1;
		step(8);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		loose.highVolt = 1'b0;
		loose.modeLatch = 1'b0;
		loose.dirPrecharge = 1'b1;
		loose.option_read_enable = 1'b0;
		loose.clampBypass = 1'b0;
		loose.chipSelN = 1'b1;
		loose.program_strobe_n = 1'b1;
		loose.addrCountClk = 1'b0;
		loose.addr_count_clear = 1'b0;
		loose.hostDataOut = 8'h00;
		loose.hostDataOe = 1'b0;
		step(4);
		rstn = 1'b1;
		step(1);
		t_after_reset();
		t_option(8'h05, 3'h5);
		t_option(8'hfe, 3'h4);
		t_no_volt();
		t_pins();
		t_array(8'h5a, ERASED_BYTE);
		loose.option_read_enable = 1'b1;
		rstn = 1'b0;
		step(4);
		rstn = 1'b1;
		step(1);
		t_after_reset();
		t_array(8'ha5, 8'ha5);
		wrap_up();
	end
endmodule
